// ---- src/cis_sequencer.v ----
// Behaviour
// [RULE_01] Enabled port pins request on low level, falling, rising or either edge.
// [RULE_02] Timer requests on overflow, capture or compare match.
// [RULE_03] Serial interface requests when a transmission completes.
// [RULE_04] No hardware request is taken while the mask bit is one.
// [RULE_05] Masked requests stay pending and are taken once the mask clears.
// [RULE_06] Software trap runs the same entry: context save then vector fetch.
// [RULE_07] Software trap enters whatever the mask bit holds.
// [RULE_08] Entry waits for the current instruction to finish.
// [RULE_09] Entry pushes program counter, first index, accumulator, condition codes.
// [RULE_10] Entry leaves the second index register alone.
// [RULE_11] Mask bit is set after the context is saved.
// [RULE_12] Each vector is a 16-bit word read from program memory.
// [RULE_13] Vector table sits at the top of the address space.
// [RULE_14] One vector per source plus reset; reset loads the start address.
// [RULE_15] A grant reads the source's fixed vector and jumps there.
// [RULE_16] Interrupt return resumes the interrupted program at its saved address.
// [RULE_17] Return pops condition codes, accumulator, first index, program counter.
// [RULE_18] One grant at a time by fixed source order; others stay pending.
`timescale 1ns/1ps
`include "cis_defs.vh"

module cis_sequencer (
	input wire clk_sys,
	input wire rst_n,
	input wire [2:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	output wire irq_out,
	input wire [7:0] pin_in,
	input wire tmr_ovf,
	input wire tmr_cap,
	input wire tmr_cmp,
	input wire ser_done,
	input wire instr_done,
	input wire trap_exec,
	input wire interrupt_return_instruction,
	input wire [15:0] core_pc,
	input wire [7:0] core_x,
	input wire [7:0] core_a,
	input wire [7:0] core_cc,
	input wire [15:0] core_sp,
	output wire core_hold,
	output reg ctx_load,
	output reg [15:0] pc_out,
	output reg [7:0] x_out,
	output reg [7:0] a_out,
	output reg [7:0] cc_out,
	output reg [15:0] sp_out,
	output reg [15:0] mem_addr,
	output reg [7:0] mem_wdata,
	output reg mem_we,
	output reg mem_re,
	input wire [7:0] mem_rdata
);

localparam S_RST = 5'h01;
localparam S_IDLE = 5'h02;
localparam S_PUSH = 5'h04;
localparam S_VEC = 5'h08;
localparam S_POP = 5'h10;

// Fixed order: lowest pending source index wins
function [2:0] cis_pick;
	input [4:0] req;
	integer i;
	begin
		cis_pick = 3'h0;
		for (i = `CIS_NSRC - 1; i >= 0; i = i - 1)
			if (req[i])
				cis_pick = i[2:0];
	end
endfunction

// Vector word address for a source, below the trap and reset entries
function [15:0] cis_vec;
	input [2:0] idx;
	begin
		cis_vec = `CIS_VEC_SRC0 - {12'h000, idx, 1'b0};
	end
endfunction

reg [4:0] state_q;
reg [4:0] state_d;
reg [2:0] cnt_q;
reg [15:0] vec_q;
reg kind_trap_q;
reg [7:0] pin_en_q;
reg [15:0] mode_q;
reg [4:1] src_en_q;
reg [7:0] pin_flag_q;
reg [4:1] pend_q;
reg [2:0] evt_q;
reg [2:0] evt_mask_q;
reg [2:0] evt_set;
wire [7:0] edge_hit;
wire [7:0] level_hit;
wire [4:0] hw_req;
wire masked;
wire rd_evt;
wire grant_hw;
wire grant_trap;
wire grant_ret;

// Per-pin detectors
genvar g;
generate
	for (g = 0; g < 8; g = g + 1)
	begin : pin_det
		cis_pin_detect u_det (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.pin(pin_in[g]),
			.en(pin_en_q[g]),
			.mode(mode_q[2*g+1:2*g]),
			.edge_hit(edge_hit[g]),
			.level_hit(level_hit[g])
		);
	end
endgenerate

// Combined requests; enables gate the timer and serial flags
assign hw_req[`CIS_SRC_PORT] = |(pin_flag_q | level_hit); // RULE_01
assign hw_req[4:1] = pend_q & src_en_q; // RULE_02 RULE_03
assign masked = core_cc[`CIS_CC_I];

// Grants only at an instruction boundary
assign grant_ret = state_q[1] & instr_done & interrupt_return_instruction; // RULE_16
assign grant_trap = state_q[1] & instr_done & trap_exec & ~interrupt_return_instruction; // RULE_07
assign grant_hw = state_q[1] & instr_done & ~trap_exec & ~interrupt_return_instruction
	& ~masked & (|hw_req); // RULE_04 RULE_05 RULE_08

assign core_hold = ~state_q[1];
assign irq_out = |(evt_q & evt_mask_q);
assign rd_evt = reg_rd & (reg_addr == `CIS_A_EVT_STAT);

// Register writes and configuration
always @(posedge clk_sys)
begin
	if (!rst_n)
	begin
		pin_en_q <= 8'h00;
		mode_q <= {`CIS_MODE_RESET, `CIS_MODE_RESET};
		src_en_q <= 4'h0;
		evt_mask_q <= 3'h0;
	end
	else if (reg_wr)
	begin
		case (reg_addr)
			`CIS_A_PIN_EN: pin_en_q <= reg_wdata;
			`CIS_A_MODE_LO: mode_q[7:0] <= reg_wdata;
			`CIS_A_MODE_HI: mode_q[15:8] <= reg_wdata;
			`CIS_A_SRC_EN: src_en_q <= reg_wdata[4:1];
			`CIS_A_EVT_MASK: evt_mask_q <= reg_wdata[2:0];
			default: ;
		endcase
	end
end

// Sticky request flags: write one clears, a new event wins
always @(posedge clk_sys)
begin
	if (!rst_n)
	begin
		pin_flag_q <= 8'h00;
		pend_q <= 4'h0;
	end
	else
	begin
		pin_flag_q <= (pin_flag_q & ~((reg_wr && reg_addr == `CIS_A_PIN_FLAG) ?
			reg_wdata : 8'h00)) | edge_hit; // RULE_01 RULE_05
		pend_q <= (pend_q & ~((reg_wr && reg_addr == `CIS_A_PEND) ?
			reg_wdata[4:1] : 4'h0))
			| ({ser_done, tmr_cmp, tmr_cap, tmr_ovf} & src_en_q); // RULE_02 RULE_03 RULE_05
	end
end

// Event status: read clears, a new event wins
always @(posedge clk_sys)
begin
	if (!rst_n)
		evt_q <= 3'h0;
	else
		evt_q <= (evt_q & ~(rd_evt ? 3'h7 : 3'h0)) | evt_set;
end

// Read data one cycle after the strobe
always @(posedge clk_sys)
begin
	if (!rst_n)
		reg_rdata <= 8'h00;
	else if (reg_rd)
	begin
		case (reg_addr)
			`CIS_A_PIN_EN: reg_rdata <= pin_en_q;
			`CIS_A_MODE_LO: reg_rdata <= mode_q[7:0];
			`CIS_A_MODE_HI: reg_rdata <= mode_q[15:8];
			`CIS_A_SRC_EN: reg_rdata <= {3'h0, src_en_q, 1'b0};
			`CIS_A_PIN_FLAG: reg_rdata <= pin_flag_q | level_hit;
			`CIS_A_PEND: reg_rdata <= {core_hold, 2'h0, hw_req};
			`CIS_A_EVT_STAT: reg_rdata <= {5'h00, evt_q};
			default: reg_rdata <= {5'h00, evt_mask_q};
		endcase
	end
	else
		reg_rdata <= 8'h00;
end

// Next state
always @*
begin
	state_d = state_q;
	case (state_q)
		S_RST: state_d = S_VEC;
		S_IDLE:
			if (grant_ret)
				state_d = S_POP;
			else if (grant_trap | grant_hw)
				state_d = S_PUSH; // RULE_06 RULE_08
		S_PUSH:
			if (cnt_q == `CIS_PUSH_LAST)
				state_d = S_VEC; // RULE_06 RULE_11
		S_VEC:
			if (cnt_q == `CIS_VEC_LAST)
				state_d = S_IDLE;
		S_POP:
			if (cnt_q == `CIS_POP_LAST)
				state_d = S_IDLE;
		default: state_d = S_RST;
	endcase
end

// Event pulses raised when an entry or return sequence completes, not after the reset vector fetch
always @*
begin
	evt_set = 3'h0;
	if (state_q[3] && cnt_q == `CIS_VEC_LAST && vec_q != `CIS_VEC_RESET)
	begin
		evt_set[`CIS_EVT_ENTRY] = 1'b1;
		evt_set[`CIS_EVT_TRAP] = kind_trap_q;
	end
	if (state_q[4] && cnt_q == `CIS_POP_LAST)
		evt_set[`CIS_EVT_RETURN] = 1'b1;
end

// Sequencer datapath
always @(posedge clk_sys)
begin
	if (!rst_n)
	begin
		state_q <= S_RST;
		cnt_q <= 3'h0;
		vec_q <= `CIS_VEC_RESET; // RULE_14
		kind_trap_q <= 1'b0;
		ctx_load <= 1'b0;
		pc_out <= 16'h0000;
		x_out <= 8'h00;
		a_out <= 8'h00;
		cc_out <= `CIS_CC_RESET;
		sp_out <= `CIS_SP_RESET;
		mem_addr <= 16'h0000;
		mem_wdata <= 8'h00;
		mem_we <= 1'b0;
		mem_re <= 1'b0;
	end
	else
	begin
		state_q <= state_d;
		ctx_load <= 1'b0;
		mem_we <= 1'b0;
		mem_re <= 1'b0;
		case (state_q)
			S_IDLE:
			begin
				cnt_q <= 3'h0;
				// Snapshot context; the second index register is not involved
				pc_out <= core_pc; // RULE_10
				x_out <= core_x;
				a_out <= core_a;
				cc_out <= core_cc;
				sp_out <= core_sp;
				kind_trap_q <= grant_trap;
				if (grant_trap)
					vec_q <= `CIS_VEC_TRAP; // RULE_06
				else
					vec_q <= cis_vec(cis_pick(hw_req)); // RULE_15 RULE_18
			end
			S_PUSH:
			begin
				// Push low PC, high PC, X, A, then CC
				mem_we <= 1'b1;
				mem_addr <= sp_out;
				sp_out <= sp_out - 16'h0001;
				cnt_q <= cnt_q + 3'h1;
				case (cnt_q)
					3'h0: mem_wdata <= pc_out[7:0]; // RULE_09
					3'h1: mem_wdata <= pc_out[15:8]; // RULE_09
					3'h2: mem_wdata <= x_out; // RULE_09
					3'h3: mem_wdata <= a_out; // RULE_09
					default: mem_wdata <= cc_out; // RULE_09
				endcase
				if (cnt_q == `CIS_PUSH_LAST)
					cnt_q <= 3'h0;
			end
			S_VEC:
			begin
				// Two byte reads of the vector word, high byte first
				cnt_q <= cnt_q + 3'h1;
				if (cnt_q == 3'h0 || cnt_q == 3'h1)
				begin
					mem_re <= 1'b1;
					mem_addr <= vec_q + {15'h0000, cnt_q[0]}; // RULE_12 RULE_13
				end
				if (cnt_q == 3'h2)
					pc_out[15:8] <= mem_rdata; // RULE_12
				if (cnt_q == `CIS_VEC_LAST)
				begin
					pc_out[7:0] <= mem_rdata; // RULE_14 RULE_15
					cc_out[`CIS_CC_I] <= 1'b1; // RULE_11
					ctx_load <= 1'b1;
					cnt_q <= 3'h0;
				end
			end
			S_POP:
			begin
				// Reads issued in steps 0..4, data taken two steps later
				cnt_q <= cnt_q + 3'h1;
				if (cnt_q <= 3'h4)
				begin
					mem_re <= 1'b1;
					mem_addr <= sp_out + 16'h0001;
					sp_out <= sp_out + 16'h0001;
				end
				case (cnt_q)
					3'h2: cc_out <= mem_rdata; // RULE_17
					3'h3: a_out <= mem_rdata; // RULE_17
					3'h4: x_out <= mem_rdata; // RULE_17
					3'h5: pc_out[15:8] <= mem_rdata; // RULE_17
					3'h6:
					begin
						pc_out[7:0] <= mem_rdata; // RULE_16
						ctx_load <= 1'b1;
						cnt_q <= 3'h0;
					end
					default: ;
				endcase
			end
			default: cnt_q <= 3'h0;
		endcase
	end
end

endmodule

// ---- shared/cis_defs.vh ----
`ifndef CIS_DEFS_VH
`define CIS_DEFS_VH

// Register addresses
`define CIS_A_PIN_EN 3'h0
`define CIS_A_MODE_LO 3'h1
`define CIS_A_MODE_HI 3'h2
`define CIS_A_SRC_EN 3'h3
`define CIS_A_PIN_FLAG 3'h4
`define CIS_A_PEND 3'h5
`define CIS_A_EVT_STAT 3'h6
`define CIS_A_EVT_MASK 3'h7

// Pin trigger modes
`define CIS_MODE_LOW 2'h0
`define CIS_MODE_FALL 2'h1
`define CIS_MODE_RISE 2'h2
`define CIS_MODE_BOTH 2'h3

// Source positions, lower index wins
`define CIS_SRC_PORT 0
`define CIS_SRC_OVF 1
`define CIS_SRC_CAP 2
`define CIS_SRC_CMP 3
`define CIS_SRC_SER 4
`define CIS_NSRC 5

// Event status bits
`define CIS_EVT_ENTRY 0
`define CIS_EVT_RETURN 1
`define CIS_EVT_TRAP 2

// Vector table at the top of the address space
`define CIS_VEC_RESET 16'hfffe
`define CIS_VEC_TRAP 16'hfffc
`define CIS_VEC_SRC0 16'hfffa

// Condition code mask bit and reset values
`define CIS_CC_I 3
`define CIS_CC_RESET 8'h08
`define CIS_SP_RESET 16'h01ff
`define CIS_MODE_RESET 8'h00

// Last step number of each sequence
`define CIS_PUSH_LAST 3'h4
`define CIS_VEC_LAST 3'h3
`define CIS_POP_LAST 3'h6

`endif

// ---- src/cis_pin_detect.v ----
`timescale 1ns/1ps
`include "cis_defs.vh"

// Per-pin trigger detection
module cis_pin_detect (
	input wire clk_sys,
	input wire rst_n,
	input wire pin,
	input wire en,
	input wire [1:0] mode,
	output reg edge_hit,
	output wire level_hit
);

reg prev_q;
wire fall;
wire rise;

// Previous level for edge compare
always @(posedge clk_sys)
begin
	if (!rst_n)
		prev_q <= 1'b1;
	else
		prev_q <= pin;
end

assign fall = prev_q & ~pin;
assign rise = ~prev_q & pin;

// Low level requests while the pin stays low
assign level_hit = en & (mode == `CIS_MODE_LOW) & ~pin; // RULE_01

// Edge selection
always @*
begin
	case (mode)
		`CIS_MODE_FALL: edge_hit = en & fall; // RULE_01
		`CIS_MODE_RISE: edge_hit = en & rise; // RULE_01
		`CIS_MODE_BOTH: edge_hit = en & (fall | rise); // RULE_01
		default: edge_hit = 1'b0;
	endcase
end

endmodule

// ---- verification/cis_seq_chk_properties.sv ----
`timescale 1ns/1ps
// Sequencing checks on the top-level ports
module cis_seq_chk (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic instr_done,
	input wire logic trap_exec,
	input wire logic interrupt_return_instruction,
	input wire logic [7:0] core_cc,
	input wire logic [15:0] core_sp,
	input wire logic core_hold,
	input wire logic ctx_load,
	input wire logic [7:0] cc_out,
	input wire logic mem_we,
	input wire logic mem_re,
	input wire logic [15:0] mem_addr
);
	// Grant at a boundary, trap grant and return grant
	wire g = instr_done && !core_hold;
	wire t = g && trap_exec && !interrupt_return_instruction;
	wire r = g && interrupt_return_instruction;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	property p_rst;
		$rose(rst_n) |-> ##[1:3] (mem_re && mem_addr == 16'hfffe);
	endproperty
	a_rst: assert property (p_rst) else $error("no reset vector read");
	property p_trap;
		t |=> core_hold;
	endproperty
	a_trap: assert property (p_trap) else $error("trap not taken");
	property p_mask;
		g && core_cc[3] && !trap_exec && !interrupt_return_instruction |=> !core_hold;
	endproperty
	a_mask: assert property (p_mask) else $error("entry while masked");
	property p_bound;
		$rose(core_hold) |-> $past(instr_done);
	endproperty
	a_bound: assert property (p_bound) else $error("entry off boundary");
	property p_push;
		t |-> ##2 (mem_we && mem_addr == $past(core_sp, 2));
	endproperty
	a_push: assert property (p_push) else $error("first push wrong");
	property p_vec;
		t |-> ##7 (mem_re && mem_addr == 16'hfffc) ##3 (ctx_load && cc_out[3]);
	endproperty
	a_vec: assert property (p_vec) else $error("trap vector or mask wrong");
	property p_pop;
		r |-> ##2 (mem_re && mem_addr == $past(core_sp, 2) + 16'h0001) ##6 ctx_load;
	endproperty
	a_pop: assert property (p_pop) else $error("return pop wrong");
	property p_nowe;
		r |=> !mem_we [*8];
	endproperty
	a_nowe: assert property (p_nowe) else $error("write during return");
endmodule

bind cis_sequencer cis_seq_chk i_cis_seq_chk (.*);

// ---- verification/cis_mem_model.sv ----
`timescale 1ns/1ps
// Program memory and stack behind the sequencer
module cis_mem_model (
	input wire logic clk_sys,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_we,
	input wire logic mem_re,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:65535];
	// Each byte a known function of its address
	initial
	begin
		mem_rdata = 8'h00;
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'(i) ^ 8'h3c;
	end
	// Data valid only after a read, scrambled otherwise
	always @(posedge clk_sys)
	begin
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
		mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
	end
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_q = 0;
	logic instr_done = 0, trap_exec = 0, interrupt_return_instruction = 0;
	logic tmr_ovf = 0, tmr_cap = 0, tmr_cmp = 0, ser_done = 0;
	logic irq_out, core_hold, ctx_load, mem_we, mem_re;
	logic [2:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, pin_in = 8'hff, core_x = 0, core_a = 0, core_cc = 0;
	logic [7:0] reg_rdata, x_out, a_out, cc_out, mem_wdata, mem_rdata;
	logic [15:0] core_pc = 0, core_sp = 0, pc_out, sp_out, mem_addr;
	logic [55:0] sv;
	logic [55:0] qc[$];
	logic [7:0] qr[$];
	int mismatches = 0, total_checks = 0;

	always #50 clk_sys = ~clk_sys;

	cis_sequencer i_cis_sequencer (.*);
	cis_mem_model i_cis_mem_model (.*);

	function automatic logic [15:0] vec(input logic [15:0] v);
		vec = {v[7:0] ^ 8'h3c, (v[7:0] + 8'h01) ^ 8'h3c};
	endfunction

	task automatic cmp_ctx(input logic [55:0] g, input logic [55:0] e);
		total_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic cmp_val(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Watch outputs, pop oldest note, follow the core context
	always @(posedge clk_sys)
	begin
		rd_q <= reg_rd;
		if (rd_q)
			cmp_val(reg_rdata, qr.size() ? qr.pop_front() : 8'h00);
		if (ctx_load)
		begin
			cmp_ctx({pc_out, x_out, a_out, cc_out, sp_out},
				qc.size() ? qc.pop_front() : 56'h0);
			core_pc <= pc_out;
			core_x <= x_out;
			core_a <= a_out;
			core_cc <= cc_out;
			core_sp <= sp_out;
		end
	end

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		qr.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
	endtask

	// One instruction boundary, then room for a whole sequence
	task automatic bnd(input logic t, input logic r);
		@(posedge clk_sys);
		instr_done <= 1'b1;
		trap_exec <= t;
		interrupt_return_instruction <= r;
		@(posedge clk_sys);
		instr_done <= 1'b0;
		repeat (12) @(posedge clk_sys);
	endtask

	task automatic ent(input logic [15:0] v, input logic t);
		@(posedge clk_sys);
		sv = {core_pc, core_x, core_a, core_cc, core_sp};
		qc.push_back({vec(v), sv[39:24], sv[23:16] | 8'h08, sv[15:0] - 16'h0005});
		bnd(t, 1'b0);
		core_pc <= 16'($urandom);
		core_x <= 8'($urandom);
		core_a <= 8'($urandom);
	endtask

	task automatic rti;
		qc.push_back(sv);
		bnd(1'b0, 1'b1);
	endtask

	// Main sequence
	initial
	begin
		void'($urandom(28));
		qc.push_back({vec(16'hfffe), 16'h0000, 8'h08, 16'h01ff});
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		$display("reset test done");
		wr(3'h7, 8'h05);
		core_cc <= 8'($urandom) | 8'h08;
		ent(16'hfffc, 1'b1);
		cmp_val({7'h00, irq_out}, 8'h01);
		rd(3'h6, 8'h05);
		rti;
		cmp_val({7'h00, irq_out}, 8'h00);
		rd(3'h6, 8'h02);
		$display("trap test done");
		wr(3'h3, 8'hff);
		rd(3'h3, 8'h1e);
		wr(3'h2, 8'h9c);
		rd(3'h2, 8'h9c);
		rd(3'h7, 8'h05);
		{tmr_ovf, tmr_cap, tmr_cmp, ser_done} <= 4'hf;
		@(posedge clk_sys);
		{tmr_ovf, tmr_cap, tmr_cmp, ser_done} <= 4'h0;
		bnd(1'b0, 1'b0);
		rd(3'h5, 8'h1e);
		core_cc <= 8'($urandom) & 8'hf7;
		for (int k = 1; k < 5; k++)
		begin
			ent(16'hfffa - 16'(2 * k), 1'b0);
			wr(3'h5, 8'(1 << k));
			rti;
		end
		rd(3'h5, 8'h00);
		$display("timer and serial test done");
		wr(3'h0, 8'h01);
		rd(3'h0, 8'h01);
		for (int m = 0; m < 4; m++)
		begin
			wr(3'h1, 8'(m));
			wr(3'h4, 8'hff);
			pin_in[0] <= 1'b0;
			repeat (3) @(posedge clk_sys);
			rd(3'h4, {7'h00, m != 2});
			wr(3'h4, 8'hff);
			pin_in[0] <= 1'b1;
			repeat (3) @(posedge clk_sys);
			rd(3'h4, {7'h00, m[1]});
		end
		$display("pin mode test done");
		wr(3'h1, 8'h00);
		wr(3'h4, 8'hff);
		pin_in[0] <= 1'b0;
		ser_done <= 1'b1;
		@(posedge clk_sys);
		ser_done <= 1'b0;
		rd(3'h5, 8'h11);
		ent(16'hfffa, 1'b0);
		pin_in[0] <= 1'b1;
		rti;
		ent(16'hfff2, 1'b0);
		wr(3'h5, 8'h10);
		rti;
		$display("priority test done");
		stop_test();
	end

	// Cut a hang short
	initial
	begin
		#3000000;
		mismatches++;
		stop_test();
	end
endmodule
